// ==== verilog/mcuil_pkg.sv ====
/*
  Constants, register map and carrier types of the interrupt logic.
  Assumes a core whose instruction cycle is four clock phases on ref_clk.
*/
package mcuil_pkg;

  // ----------------------------------------
  // Register indexes and byte addresses
  // ----------------------------------------
  localparam int          AW        = 10;
  localparam logic [7:0]  IDX_OPT   = 8'h81;
  localparam logic [7:0]  IDX_ICTL  = 8'h0B;
  localparam logic [7:0]  IDX_PFLG  = 8'h0C;
  localparam logic [7:0]  IDX_PEN   = 8'h8C;
  localparam logic [7:0]  IDX_PCS   = 8'h96;
  localparam logic [7:0]  IDX_ASEL  = 8'h9F;
  localparam logic [7:0]  IDX_STAT  = 8'hF0;
  localparam logic [9:0]  ADDR_OPT  = {IDX_OPT, 2'b00};
  localparam logic [9:0]  ADDR_ICTL = {IDX_ICTL, 2'b00};
  localparam logic [9:0]  ADDR_PFLG = {IDX_PFLG, 2'b00};
  localparam logic [9:0]  ADDR_PEN  = {IDX_PEN, 2'b00};
  localparam logic [9:0]  ADDR_PCS  = {IDX_PCS, 2'b00};
  localparam logic [9:0]  ADDR_ASEL = {IDX_ASEL, 2'b00};
  localparam logic [9:0]  ADDR_STAT = {IDX_STAT, 2'b00};

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0]  OPT_RST   = 8'hFF;
  localparam logic [7:0]  ICTL_RST  = 8'h00;
  localparam logic [7:0]  PFLG_RST  = 8'h00;
  localparam logic [7:0]  PEN_RST   = 8'h00;
  localparam logic [5:0]  PCS_RST   = 6'h00;
  localparam logic        ASEL_RST  = 1'b1;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int          OPT_EDGE  = 6;
  localparam int          GLB_EN    = 7;
  localparam int          PER_EN    = 6;
  localparam int          TMR_EN    = 5;
  localparam int          PIN_EN    = 4;
  localparam int          PCH_EN    = 3;
  localparam int          TMR_FLG   = 2;
  localparam int          PIN_FLG   = 1;
  localparam int          PCH_FLG   = 0;
  localparam int          CONV_BIT  = 6;
  localparam logic [7:0]  PFLG_MASK = 8'hC9;
  localparam int          PORT_W    = 6;
  localparam int          PC_W      = 13;
  localparam logic [12:0] VECTOR    = 13'h0004;
  localparam logic [7:0]  TMR_MAX   = 8'hFF;
  localparam logic [7:0]  TMR_ZERO  = 8'h00;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int          CLK_NS    = 25;
  localparam int          TCY_CLKS  = 4;
  localparam int          DUMMY_TCY = 2;
  localparam int          LOAD_CLKS = DUMMY_TCY * TCY_CLKS + 1;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} mcuil_phase_t;
  typedef enum logic [1:0] {TK_IDLE, TK_DUMMY1, TK_DUMMY2} mcuil_take_t;

  typedef struct packed {
    logic            sleep_cmd;
    logic            ret_instr;
    logic            port_read;
    logic [PC_W-1:0] pc;
  } mcuil_core_in_t;

  typedef struct packed {
    logic            asleep;
    logic            wake;
    logic            push;
    logic            load;
    logic [PC_W-1:0] ret_pc;
    logic [PC_W-1:0] vector;
  } mcuil_core_out_t;

endpackage

// ==== verilog/mcuil_edge.sv ====
/*
  Edge detector for a group of synchronous inputs.
  Assumes inputs already synchronous to ref_clk.
*/
`timescale 1ns/1ps
module mcuil_edge #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst,
  // Levels in, edges out
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);

  logic [W-1:0] prev_q;

  // Previous level; a high level at release reads as one rise
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prev_q <= '0;
    end else begin
      prev_q <= din;
    end
  end

  // Edge terms
  assign rise = din & ~prev_q;
  assign fall = ~din & prev_q;

endmodule

// ==== verilog/mcuil_irq.sv ====
/*
  Interrupt logic: flags, enables, sleep wake-up and vector entry.
  Assumes an Avalon-MM master on the register port and a core that
  supplies the return address and reports sleep and return strobes.
*/
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module mcuil_irq (
  // Clock and reset
  input  wire logic                      ref_clk,
  input  wire logic                      rst,
  // Avalon-MM slave
  input  wire logic [mcuil_pkg::AW-1:0]  avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [31:0]               avs_writedata,
  input  wire logic [3:0]                avs_byteenable,
  output logic      [31:0]               avs_readdata,
  output logic                           avs_waitrequest,
  // Event sources
  input  wire logic                      ext_irq_pin,
  input  wire logic [mcuil_pkg::PORT_W-1:0] port_pins,
  input  wire logic [7:0]                timer_zero_count,
  input  wire logic [7:0]                periph_evt,
  // Core side
  input  wire mcuil_pkg::mcuil_core_in_t core_in,
  output mcuil_pkg::mcuil_core_out_t     core_out
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  mcuil_pkg::mcuil_phase_t ph_q;
  mcuil_pkg::mcuil_phase_t ph_d;
  mcuil_pkg::mcuil_take_t  tk_q;
  mcuil_pkg::mcuil_take_t  tk_d;
  logic [7:0]  opt_q;
  logic [7:0]  ictl_q;
  logic [7:0]  ictl_d;
  logic [7:0]  pflg_q;
  logic [7:0]  pflg_d;
  logic [7:0]  pen_q;
  logic [5:0]  pcs_q;
  logic        asel_q;
  logic [7:0]  tmr_prev_q;
  logic        ack_q;
  logic [31:0] rdata_q;
  logic        asleep_q;
  logic        wake_q;
  logic        push_q;
  logic        load_q;
  logic [12:0] ret_pc_q;
  logic [7:0]  rd_mux;
  logic        req;
  logic        wr_ok;
  logic [7:0]  wdata;
  logic        w_opt;
  logic        w_ictl;
  logic        w_pflg;
  logic        w_pen;
  logic        w_pcs;
  logic        w_asel;
  logic        q1;
  logic        pin_eff;
  logic        ext_rise;
  logic        ext_fall;
  logic        ext_evt;
  logic [5:0]  prt_rise;
  logic [5:0]  prt_fall;
  logic        port_evt;
  logic        tmr_evt;
  logic [7:0]  per_evt;
  logic        per_act;
  logic        src_act;
  logic        glb_en;
  logic        take;

  // Write select for one register address
  function automatic logic sel(input logic [9:0] a, input logic [9:0] reg_a, input logic ok);
    return ok && (a == reg_a);
  endfunction

  // ----------------------------------------
  // Avalon-MM slave
  // ----------------------------------------
  // One wait state: data is muxed in the first cycle, answered in the second
  assign req             = avs_read || avs_write;
  assign avs_waitrequest = req && !ack_q;
  assign avs_readdata    = rdata_q;
  assign wr_ok           = avs_write && ack_q && avs_byteenable[0];
  assign wdata           = avs_writedata[7:0];
  assign w_opt           = sel(avs_address, mcuil_pkg::ADDR_OPT, wr_ok);
  assign w_ictl          = sel(avs_address, mcuil_pkg::ADDR_ICTL, wr_ok);
  assign w_pflg          = sel(avs_address, mcuil_pkg::ADDR_PFLG, wr_ok);
  assign w_pen           = sel(avs_address, mcuil_pkg::ADDR_PEN, wr_ok);
  assign w_pcs           = sel(avs_address, mcuil_pkg::ADDR_PCS, wr_ok);
  assign w_asel          = sel(avs_address, mcuil_pkg::ADDR_ASEL, wr_ok);

  // Read mux; unmapped addresses read zero
  always_comb begin
    rd_mux = 8'h00;
    if (avs_address == mcuil_pkg::ADDR_OPT) begin
      rd_mux = opt_q;
    end else if (avs_address == mcuil_pkg::ADDR_ICTL) begin
      rd_mux = ictl_q;
    end else if (avs_address == mcuil_pkg::ADDR_PFLG) begin
      rd_mux = pflg_q;
    end else if (avs_address == mcuil_pkg::ADDR_PEN) begin
      rd_mux = pen_q;
    end else if (avs_address == mcuil_pkg::ADDR_PCS) begin
      rd_mux = {2'b00, pcs_q};
    end else if (avs_address == mcuil_pkg::ADDR_ASEL) begin
      rd_mux = {7'h00, asel_q};
    end else if (avs_address == mcuil_pkg::ADDR_STAT) begin
      rd_mux = {4'h0, tk_q != mcuil_pkg::TK_IDLE, asleep_q, ph_q};
    end
  end

  // Bus handshake and read data
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= req && !ack_q;
      if (req && !ack_q) begin
        rdata_q <= {24'h00_0000, rd_mux};
      end
    end
  end

  // ----------------------------------------
  // Event detection
  // ----------------------------------------
  // Analog-selected pin reads zero, so it shows no edge after the first cycle of selection (a high pin falls then)
  assign pin_eff = ext_irq_pin && !asel_q;

  mcuil_edge #(.W(1)) u_ext_edge (
    .ref_clk (ref_clk),
    .rst     (rst),
    .din     (pin_eff),
    .rise    (ext_rise),
    .fall    (ext_fall)
  );

  mcuil_edge #(.W(mcuil_pkg::PORT_W)) u_port_edge (
    .ref_clk (ref_clk),
    .rst     (rst),
    .din     (port_pins),
    .rise    (prt_rise),
    .fall    (prt_fall)
  );

  // Edge polarity from option bit; accepted in every phase
  assign ext_evt  = opt_q[mcuil_pkg::OPT_EDGE] ? ext_rise : ext_fall;
  // A change landing on a Q2 port read is dropped; an accepted hazard
  assign port_evt = (|((prt_rise | prt_fall) & pcs_q))
                    && !(core_in.port_read && ph_q == mcuil_pkg::PH_Q2);
  assign tmr_evt  = (tmr_prev_q == mcuil_pkg::TMR_MAX)
                    && (timer_zero_count == mcuil_pkg::TMR_ZERO);
  assign per_evt  = periph_evt & mcuil_pkg::PFLG_MASK;

  // ----------------------------------------
  // Flag and enable registers
  // ----------------------------------------
  // Hardware set wins over a software clear in the same cycle
  always_comb begin
    ictl_d = w_ictl ? wdata : ictl_q;
    ictl_d[mcuil_pkg::PIN_FLG] = ictl_d[mcuil_pkg::PIN_FLG] | ext_evt;
    ictl_d[mcuil_pkg::TMR_FLG] = ictl_d[mcuil_pkg::TMR_FLG] | tmr_evt;
    ictl_d[mcuil_pkg::PCH_FLG] = ictl_d[mcuil_pkg::PCH_FLG] | port_evt;
    if (take) begin
      ictl_d[mcuil_pkg::GLB_EN] = 1'b0;
    end else if (core_in.ret_instr) begin
      ictl_d[mcuil_pkg::GLB_EN] = 1'b1;
    end
  end

  // Peripheral flags, only implemented bits kept
  assign pflg_d = ((w_pflg ? wdata : pflg_q) & mcuil_pkg::PFLG_MASK) | per_evt;

  // Register storage; global enable cleared by reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      opt_q      <= mcuil_pkg::OPT_RST;
      ictl_q     <= mcuil_pkg::ICTL_RST;
      pflg_q     <= mcuil_pkg::PFLG_RST;
      pen_q      <= mcuil_pkg::PEN_RST;
      pcs_q      <= mcuil_pkg::PCS_RST;
      asel_q     <= mcuil_pkg::ASEL_RST;
      tmr_prev_q <= mcuil_pkg::TMR_ZERO;
    end else begin
      ictl_q     <= ictl_d;
      pflg_q     <= pflg_d;
      tmr_prev_q <= timer_zero_count;
      if (w_opt) begin
        opt_q <= wdata;
      end
      if (w_pen) begin
        pen_q <= wdata & mcuil_pkg::PFLG_MASK;
      end
      if (w_pcs) begin
        pcs_q <= wdata[5:0];
      end
      if (w_asel) begin
        asel_q <= wdata[0];
      end
    end
  end

  // ----------------------------------------
  // Request gating and entry sequence
  // ----------------------------------------
  // Each source needs its own enable; peripherals also need the group enable
  assign per_act = ictl_q[mcuil_pkg::PER_EN] && |(pflg_q & pen_q);
  assign src_act = (ictl_q[mcuil_pkg::PIN_FLG] && ictl_q[mcuil_pkg::PIN_EN])
                || (ictl_q[mcuil_pkg::TMR_FLG] && ictl_q[mcuil_pkg::TMR_EN])
                || (ictl_q[mcuil_pkg::PCH_FLG] && ictl_q[mcuil_pkg::PCH_EN])
                || per_act;
  assign glb_en  = ictl_q[mcuil_pkg::GLB_EN];
  assign q1      = ph_q == mcuil_pkg::PH_Q1;
  // Sampled only at Q1 and only while awake and globally enabled
  assign take    = q1 && tk_q == mcuil_pkg::TK_IDLE && !asleep_q
                && glb_en && src_act;

  // Phase walk and entry state; two dummy cycles regardless of instruction
  always_comb begin
    ph_d = mcuil_pkg::PH_Q1;
    case (ph_q)
      mcuil_pkg::PH_Q1: ph_d = mcuil_pkg::PH_Q2;
      mcuil_pkg::PH_Q2: ph_d = mcuil_pkg::PH_Q3;
      mcuil_pkg::PH_Q3: ph_d = mcuil_pkg::PH_Q4;
      default:          ph_d = mcuil_pkg::PH_Q1;
    endcase
    tk_d = tk_q;
    case (tk_q)
      mcuil_pkg::TK_IDLE: begin
        if (take) begin
          tk_d = mcuil_pkg::TK_DUMMY1;
        end
      end
      mcuil_pkg::TK_DUMMY1: begin
        if (q1) begin
          tk_d = mcuil_pkg::TK_DUMMY2;
        end
      end
      default: begin
        if (q1) begin
          tk_d = mcuil_pkg::TK_IDLE;
        end
      end
    endcase
  end

  // Entry outputs; only the return address is handed to the stack
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ph_q     <= mcuil_pkg::PH_Q1;
      tk_q     <= mcuil_pkg::TK_IDLE;
      push_q   <= 1'b0;
      load_q   <= 1'b0;
      ret_pc_q <= 13'h0000;
    end else begin
      ph_q   <= ph_d;
      tk_q   <= tk_d;
      push_q <= take;
      load_q <= (tk_q == mcuil_pkg::TK_DUMMY2) && q1;
      if (take) begin
        ret_pc_q <= core_in.pc;
      end
    end
  end

  // Sleep: any enabled flag wakes, global enable not needed
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      asleep_q <= 1'b0;
      wake_q   <= 1'b0;
    end else begin
      wake_q <= asleep_q && src_act;
      if (asleep_q && src_act) begin
        asleep_q <= 1'b0;
      end else if (core_in.sleep_cmd) begin
        asleep_q <= 1'b1;
      end
    end
  end

  assign core_out = '{asleep: asleep_q, wake: wake_q, push: push_q, load: load_q,
                      ret_pc: ret_pc_q, vector: mcuil_pkg::VECTOR};

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_rise_sets;
    opt_q[mcuil_pkg::OPT_EDGE] && !asel_q && $rose(ext_irq_pin) |=> ictl_q[mcuil_pkg::PIN_FLG];
  endproperty
  a_rise_sets: assert property (p_rise_sets) else $error("rising edge lost");

  property p_fall_sets;
    !opt_q[mcuil_pkg::OPT_EDGE] && !asel_q && $fell(ext_irq_pin) |=> ictl_q[mcuil_pkg::PIN_FLG];
  endproperty
  a_fall_sets: assert property (p_fall_sets) else $error("falling edge lost");

  property p_analog_quiet;
    asel_q && !ictl_q[mcuil_pkg::PIN_FLG] && !w_ictl |=> !ictl_q[mcuil_pkg::PIN_FLG];
  endproperty
  a_analog_quiet: assert property (p_analog_quiet) else $error("analog pin set flag");

  property p_tmr_wrap;
    $past(timer_zero_count) == 8'hFF && timer_zero_count == 8'h00 |=> ictl_q[mcuil_pkg::TMR_FLG];
  endproperty
  a_tmr_wrap: assert property (p_tmr_wrap) else $error("timer wrap lost");

  property p_masked;
    !ictl_q[mcuil_pkg::PIN_EN] && !ictl_q[mcuil_pkg::TMR_EN] && !ictl_q[mcuil_pkg::PCH_EN]
      && !ictl_q[mcuil_pkg::PER_EN] |-> !take;
  endproperty
  a_masked: assert property (p_masked) else $error("masked source taken");

  property p_latency;
    take |-> ##1 push_q ##1 !load_q [*7] ##1 load_q;
  endproperty
  a_latency: assert property (p_latency) else $error("vector load latency wrong");

  property p_entry;
    take |=> !glb_en && push_q && ret_pc_q == $past(core_in.pc);
  endproperty
  a_entry: assert property (p_entry) else $error("entry did not clear enable or push");

  property p_q1_only;
    push_q |-> $past(ph_q) == mcuil_pkg::PH_Q1;
  endproperty
  a_q1_only: assert property (p_q1_only) else $error("request taken outside Q1");

  property p_ret_sets;
    core_in.ret_instr && !take |=> glb_en;
  endproperty
  a_ret_sets: assert property (p_ret_sets) else $error("return did not set enable");

  property p_wake;
    asleep_q && src_act |=> !asleep_q && wake_q;
  endproperty
  a_wake: assert property (p_wake) else $error("enabled source did not wake");

  property p_conv;
    periph_evt[mcuil_pkg::CONV_BIT] |=> pflg_q[mcuil_pkg::CONV_BIT];
  endproperty
  a_conv: assert property (p_conv) else $error("conversion flag lost");

  c_take: cover property (take);
  c_wake: cover property (wake_q);
  c_port: cover property (port_evt);
  c_load: cover property (load_q);

endmodule

// ==== sim/mcuil_core_model.sv ====
/*
  Behavioural core partner of the interrupt logic: program counter,
  sleep and return strobes, and a tally of entries, wakes and latency.
  Assumes the bench pulses its requests just after a rising clock edge.
*/
`timescale 1ns/1ps
module mcuil_core_model (
  // Clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       rst,
  // Requests from the bench
  input  wire logic                       sleep_req,
  input  wire logic                       ret_req,
  input  wire logic                       rd_port,
  // Core interface
  input  wire mcuil_pkg::mcuil_core_out_t core_out,
  output mcuil_pkg::mcuil_core_in_t       core_in,
  // Observations
  output logic [7:0]                      entry_cnt,
  output logic [7:0]                      wake_cnt,
  output logic [7:0]                      load_gap,
  output logic [12:0]                     pc_at_take
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [1:0]  ph_q;
  logic [12:0] pc_q;
  logic [12:0] pc_prev_q;
  logic [15:0] cyc_q;
  logic [15:0] push_at_q;

  // Strobes pass straight through, so the bench owns their timing
  assign core_in = '{sleep_cmd: sleep_req, ret_instr: ret_req,
                     port_read: rd_port, pc: pc_q};

  // Counter steps once per four phases and stalls while asleep
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ph_q       <= 2'h0;
      pc_q       <= 13'h0000;
      pc_prev_q  <= 13'h0000;
      cyc_q      <= 16'h0000;
      push_at_q  <= 16'h0000;
      entry_cnt  <= 8'h00;
      wake_cnt   <= 8'h00;
      load_gap   <= 8'h00;
      pc_at_take <= 13'h0000;
    end else begin
      ph_q      <= ph_q + 2'h1;
      cyc_q     <= cyc_q + 16'h0001;
      pc_prev_q <= pc_q;
      if (core_out.load) begin
        pc_q     <= core_out.vector;
        load_gap <= 8'(cyc_q - push_at_q);
      end else if (ph_q == 2'h3 && !core_out.asleep) begin
        pc_q <= pc_q + 13'h0001;
      end
      if (core_out.push) begin
        entry_cnt  <= entry_cnt + 8'h01;
        push_at_q  <= cyc_q;
        pc_at_take <= pc_prev_q;
      end
      if (core_out.wake) begin
        wake_cnt <= wake_cnt + 8'h01;
      end
    end
  end
endmodule

// ==== sim/mcuil_irq_test.sv ====
/*
  Self-checking bench of the interrupt logic over its Avalon-MM port.
  Assumes the design package and the core partner model compile first.
*/
`timescale 1ns/1ps
module mcuil_irq_test;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic                       ref_clk = 1'h0;
  logic                       rst = 1'h1;
  logic [9:0]                 adr = 10'h000;
  logic                       rd = 1'h0;
  logic                       wr = 1'h0;
  logic [31:0]                wdat = 32'h0;
  logic [3:0]                 be = 4'hF;
  logic [31:0]                rdat;
  logic                       wait_rq;
  logic                       pin = 1'h0;
  logic [5:0]                 port = 6'h00;
  logic [7:0]                 tmr = 8'h00;
  logic [7:0]                 evt = 8'h00;
  logic                       slp = 1'h0;
  logic                       ret = 1'h0;
  logic                       prd = 1'h0;
  mcuil_pkg::mcuil_core_in_t  cin;
  mcuil_pkg::mcuil_core_out_t cout;
  logic [7:0]                 n_ent;
  logic [7:0]                 n_wake;
  logic [7:0]                 gap;
  logic [12:0]                tpc;
  int                         miscompares = 0;
  int                         check_count = 0;

  mcuil_irq DUT (
    .ref_clk(ref_clk), .rst(rst), .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdat),
    .avs_waitrequest(wait_rq), .ext_irq_pin(pin), .port_pins(port),
    .timer_zero_count(tmr), .periph_evt(evt), .core_in(cin), .core_out(cout)
  );
  mcuil_core_model PEER (
    .ref_clk(ref_clk), .rst(rst), .sleep_req(slp), .ret_req(ret), .rd_port(prd),
    .core_out(cout), .core_in(cin), .entry_cnt(n_ent), .wake_cnt(n_wake),
    .load_gap(gap), .pc_at_take(tpc)
  );

  // 40 MHz clock
  always #12.5 ref_clk = ~ref_clk;

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Holds the request until waitrequest is sampled low at an edge
  task automatic acc(input logic w, input logic [9:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    int n;
    n = 0;
    @(posedge ref_clk);
    adr <= a;
    wr <= w;
    rd <= !w;
    wdat <= {24'h000000, d};
    do begin
      @(posedge ref_clk);
      n++;
    end while (wait_rq !== 1'h0 && n < 50);
    q = rdat[7:0];
    rd <= 1'h0;
    wr <= 1'h0;
    if (n >= 50) begin
      miscompares++;
      end_sim();
    end
  endtask

  task automatic wreg(input logic [9:0] a, input logic [7:0] d);
    logic [7:0] q;
    acc(1'h1, a, d, q);
  endtask

  task automatic rchk(input logic [9:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] q;
    acc(1'h0, a, 8'h00, q);
    check({24'h0, q & m}, {24'h0, e});
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Source levels change together; event pulses last one cycle
  task automatic src(input logic p, input logic [5:0] g, input logic [7:0] t,
                     input logic [7:0] e);
    @(posedge ref_clk);
    pin <= p;
    port <= g;
    tmr <= t;
    evt <= e;
    @(posedge ref_clk);
    evt <= 8'h00;
    tick(2);
  endtask

  task automatic cpulse(input logic s, input logic r);
    @(posedge ref_clk);
    slp <= s;
    ret <= r;
    @(posedge ref_clk);
    slp <= 1'h0;
    ret <= 1'h0;
  endtask

  // Bounded wait on the wake tally (s=1) or the entry tally (s=0)
  task automatic await(input logic s, input logic [7:0] e);
    int n;
    n = 0;
    while ((s ? n_wake : n_ent) !== e && n < 60) begin
      @(posedge ref_clk);
      n++;
    end
    check({24'h0, s ? n_wake : n_ent}, {24'h0, e});
    if (n >= 60) begin
      end_sim();
    end
  endtask

  // Reads status until it shows Q3; the next src change then lands in Q2
  task automatic to_q3();
    logic [7:0] q;
    int n;
    n = 0;
    do begin
      acc(1'h0, mcuil_pkg::ADDR_STAT, 8'h00, q);
      n++;
    end while (q[1:0] != 2'h2 && n < 8);
    check({30'h0, q[1:0]}, 32'h2);
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    tick(10);
    rst <= 1'h0;
    rchk(mcuil_pkg::ADDR_OPT, 8'hFF, 8'hFF);
    rchk(mcuil_pkg::ADDR_ICTL, 8'hFF, 8'h00);
    rchk(mcuil_pkg::ADDR_PFLG, 8'hFF, 8'h00);
    rchk(10'h3FC, 8'hFF, 8'h00);
    be <= 4'h0;
    wreg(mcuil_pkg::ADDR_PEN, 8'h40);
    be <= 4'hF;
    rchk(mcuil_pkg::ADDR_PEN, 8'hFF, 8'h00);
    wreg(mcuil_pkg::ADDR_PEN, 8'hFF);
    rchk(mcuil_pkg::ADDR_PEN, 8'hFF, 8'hC9);
    wreg(mcuil_pkg::ADDR_PEN, 8'h00);
    // External pin: analog first, then both edge senses
    src(1'h1, 6'h00, 8'h00, 8'h00);
    rchk(mcuil_pkg::ADDR_ICTL, 8'hFF, 8'h00);
    src(1'h0, 6'h00, 8'h00, 8'h00);
    wreg(mcuil_pkg::ADDR_ASEL, 8'h00);
    src(1'h1, 6'h00, 8'h00, 8'h00);
    rchk(mcuil_pkg::ADDR_ICTL, 8'hFF, 8'h02);
    wreg(mcuil_pkg::ADDR_ICTL, 8'h00);
    wreg(mcuil_pkg::ADDR_OPT, 8'hBF);
    src(1'h0, 6'h00, 8'h00, 8'h00);
    rchk(mcuil_pkg::ADDR_ICTL, 8'hFF, 8'h02);
    wreg(mcuil_pkg::ADDR_ICTL, 8'h00);
    src(1'h1, 6'h00, 8'h00, 8'h00);
    rchk(mcuil_pkg::ADDR_ICTL, 8'hFF, 8'h00);
    // Timer wrap, pin change select, conversion pulse
    src(1'h1, 6'h00, 8'hFF, 8'h00);
    src(1'h1, 6'h00, 8'h00, 8'h00);
    rchk(mcuil_pkg::ADDR_ICTL, 8'hFF, 8'h04);
    wreg(mcuil_pkg::ADDR_ICTL, 8'h00);
    wreg(mcuil_pkg::ADDR_PCS, 8'h01);
    src(1'h1, 6'h02, 8'h00, 8'h00);
    rchk(mcuil_pkg::ADDR_ICTL, 8'hFF, 8'h00);
    src(1'h1, 6'h03, 8'h00, 8'h00);
    rchk(mcuil_pkg::ADDR_ICTL, 8'hFF, 8'h01);
    wreg(mcuil_pkg::ADDR_ICTL, 8'h00);
    // Selected pin change during a Q2 port read is dropped
    prd <= 1'h1;
    to_q3();
    src(1'h1, 6'h02, 8'h00, 8'h00);
    prd <= 1'h0;
    rchk(mcuil_pkg::ADDR_ICTL, 8'hFF, 8'h00);
    src(1'h1, 6'h03, 8'h00, 8'h44);
    rchk(mcuil_pkg::ADDR_PFLG, 8'hFF, 8'h40);
    // Timer entry, latency, return
    wreg(mcuil_pkg::ADDR_ICTL, 8'hA0);
    src(1'h1, 6'h03, 8'hFF, 8'h00);
    src(1'h1, 6'h03, 8'h00, 8'h00);
    await(1'h0, 8'h01);
    // Let the vector load land before its gap is read
    tick(10);
    check({24'h0, gap}, 32'(mcuil_pkg::DUMMY_TCY * mcuil_pkg::TCY_CLKS));
    check({19'h0, cout.ret_pc}, {19'h0, tpc});
    check({19'h0, cout.vector}, {19'h0, mcuil_pkg::VECTOR});
    rchk(mcuil_pkg::ADDR_ICTL, 8'hFF, 8'h24);
    wreg(mcuil_pkg::ADDR_ICTL, 8'h20);
    cpulse(1'h0, 1'h1);
    rchk(mcuil_pkg::ADDR_ICTL, 8'hFF, 8'hA0);
    // Masked pin, peripheral gating, masked timer
    wreg(mcuil_pkg::ADDR_ICTL, 8'h80);
    src(1'h0, 6'h03, 8'h00, 8'h00);
    tick(20);
    check({24'h0, n_ent}, 32'h1);
    rchk(mcuil_pkg::ADDR_ICTL, 8'hFF, 8'h82);
    wreg(mcuil_pkg::ADDR_ICTL, 8'h80);
    wreg(mcuil_pkg::ADDR_PEN, 8'h40);
    tick(20);
    check({24'h0, n_ent}, 32'h1);
    wreg(mcuil_pkg::ADDR_ICTL, 8'hC0);
    await(1'h0, 8'h02);
    wreg(mcuil_pkg::ADDR_PFLG, 8'h00);
    wreg(mcuil_pkg::ADDR_PEN, 8'h00);
    wreg(mcuil_pkg::ADDR_ICTL, 8'h80);
    src(1'h0, 6'h03, 8'hFF, 8'h00);
    src(1'h0, 6'h03, 8'h00, 8'h00);
    tick(20);
    check({24'h0, n_ent}, 32'h2);
    // Sleep wake without and with global enable
    wreg(mcuil_pkg::ADDR_ICTL, 8'h10);
    cpulse(1'h1, 1'h0);
    rchk(mcuil_pkg::ADDR_STAT, 8'h04, 8'h04);
    src(1'h1, 6'h03, 8'h00, 8'h00);
    src(1'h0, 6'h03, 8'h00, 8'h00);
    await(1'h1, 8'h01);
    tick(20);
    check({24'h0, n_ent}, 32'h2);
    wreg(mcuil_pkg::ADDR_ICTL, 8'h90);
    cpulse(1'h1, 1'h0);
    src(1'h1, 6'h03, 8'h00, 8'h00);
    src(1'h0, 6'h03, 8'h00, 8'h00);
    await(1'h1, 8'h02);
    await(1'h0, 8'h03);
    end_sim();
  end

  // Hang guard
  initial begin
    tick(20000);
    miscompares++;
    end_sim();
  end
endmodule
